// ### verilog/snpa_top.sv
// Serial nonvolatile RAM slave: command decode, protection, burst access.
// Assumes CLOCK_I is at least four times the serial clock rate.
`timescale 1ns/1ps
module snpa_top #(
   parameter int AW = snpa_pkg::SNPA_AW
) (
   // Clock and reset
   input  wire logic CLOCK_I,
   input  wire logic RST_N_I,
   // Serial link pins
   input  wire logic SCLK_I,
   input  wire logic SEL_N_I,
   input  wire logic SDI_I,
   input  wire logic GUARD_N_I,
   output logic      SDO_O,
   output logic      SDO_OE_O
);
   import snpa_pkg::*;

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   snpa_pins_t pins_m_q;
   snpa_pins_t pins_q;
   logic       sclk_old_q;
   logic       sel_old_q;

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pins_m_q   <= '{sclk: 1'b0, sel_n: 1'b1, sdi: 1'b0, guard_n: 1'b1};
         pins_q     <= '{sclk: 1'b0, sel_n: 1'b1, sdi: 1'b0, guard_n: 1'b1};
         sclk_old_q <= 1'b0;
         sel_old_q  <= 1'b1;
      end else begin
         pins_m_q   <= '{sclk: SCLK_I, sel_n: SEL_N_I, sdi: SDI_I,
                         guard_n: GUARD_N_I};
         pins_q     <= pins_m_q;
         sclk_old_q <= pins_q.sclk;
         sel_old_q  <= pins_q.sel_n;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic sel_fall;
   logic sel_rise;
   logic active;
   assign sclk_rise = pins_q.sclk & ~sclk_old_q;
   assign sclk_fall = ~pins_q.sclk & sclk_old_q;
   assign sel_fall  = ~pins_q.sel_n & sel_old_q;
   assign sel_rise  = pins_q.sel_n & ~sel_old_q;
   assign active    = ~pins_q.sel_n & ~sel_fall;

   // ==========================================================
   // Protection decode
   // ==========================================================
   function automatic logic guarded(input logic [1:0] g,
                                    input logic [AW-1:0] a);
      unique case (g)
         2'b00: guarded = 1'b0;
         2'b01: guarded = a >= AW'(GUARD_QUARTER);
         2'b10: guarded = a >= AW'(GUARD_HALF);
         2'b11: guarded = 1'b1;
      endcase
   endfunction

   // ==========================================================
   // Byte shifter
   // ==========================================================
   snpa_state_t   state_q;
   logic [2:0]    bit_q;
   logic [6:0]    shin_q;
   logic [7:0]    rx_byte;
   logic          byte_done;
   logic [AW-1:0] addr_q;
   logic          halted_q;
   logic          wrote_q;
   logic [7:0]    status_q;
   logic [7:0]    mem_q [0:(1<<AW)-1];
   logic [7:0]    shout_q;

   assign rx_byte   = {shin_q, pins_q.sdi};
   assign byte_done = active & sclk_rise & (bit_q == BIT_LAST);

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bit_q  <= 3'h0;
         shin_q <= 7'h00;
      end else if (!active) begin
         bit_q  <= 3'h0;
      end else if (sclk_rise) begin
         bit_q  <= bit_q + 3'h1;
         shin_q <= rx_byte[6:0];
      end
   end

   // ==========================================================
   // Command sequencer
   // ==========================================================
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q <= SNPA_OPCODE;
      end else if (!active) begin
         state_q <= SNPA_OPCODE;
      end else if (byte_done) begin
         unique case (state_q)
            SNPA_OPCODE: begin
               unique case (rx_byte)
                  OP_READ, OP_WRITE: state_q <= SNPA_ADDR_HI;
                  OP_FETCH:          state_q <= SNPA_STATUS;
                  OP_STORE:          state_q <= SNPA_SDATA;
                  OP_ARM, OP_DISARM: state_q <= SNPA_IGNORE;
                  default:           state_q <= SNPA_IGNORE;
               endcase
            end
            SNPA_ADDR_HI: state_q <= SNPA_ADDR_LO;
            SNPA_ADDR_LO: state_q <= wrote_q ? SNPA_WDATA : SNPA_RDATA;
            SNPA_SDATA:   state_q <= SNPA_IGNORE;
            SNPA_WDATA, SNPA_RDATA, SNPA_STATUS, SNPA_IGNORE: ;
         endcase
      end
   end

   // Write opcode remembered so the address phase knows its direction.
   logic is_write_op;
   assign is_write_op = (state_q == SNPA_OPCODE) && (rx_byte == OP_WRITE);

   // ==========================================================
   // Address counter and array
   // ==========================================================
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         addr_q   <= '0;
         halted_q <= 1'b0;
      end else if (byte_done) begin
         unique case (state_q)
            SNPA_OPCODE:  halted_q <= 1'b0;
            SNPA_ADDR_HI: addr_q <= {rx_byte[AW-9:0], addr_q[7:0]};
            SNPA_ADDR_LO: addr_q <= {addr_q[AW-1:8], rx_byte};
            SNPA_WDATA: begin
               if (halted_q || guarded(status_q[3:2], addr_q)) begin
                  halted_q <= 1'b1;
               end else begin
                  addr_q <= addr_q + 1'b1;
               end
            end
            SNPA_RDATA:   addr_q <= addr_q + 1'b1;
            default: ;
         endcase
      end
   end

   // Array writes depend on latch and guard only, never the pin.
   logic arr_we;
   assign arr_we = byte_done && state_q == SNPA_WDATA && status_q[1]
                   && !halted_q && !guarded(status_q[3:2], addr_q);

   always_ff @(posedge CLOCK_I) begin
      if (arr_we) begin
         mem_q[addr_q] <= rx_byte;
      end
   end

   // ==========================================================
   // Status register and write latch
   // ==========================================================
   // Guard bits model nonvolatile cells: only reset and a status store touch
   // them; a real part would keep them across power loss.
   logic pending_clr_q;
   logic store_ok;
   assign store_ok = byte_done && state_q == SNPA_SDATA && status_q[1]
                     && !(status_q[7] && !pins_q.guard_n);

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wrote_q <= 1'b0;
      end else if (byte_done && state_q == SNPA_OPCODE) begin
         wrote_q <= is_write_op;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         status_q      <= ST_RESET;
         pending_clr_q <= 1'b0;
      end else begin
         if (store_ok) begin
            status_q <= (rx_byte & ST_WRITE_MASK)
                        | (status_q & ~ST_WRITE_MASK);
         end
         if (byte_done && state_q == SNPA_OPCODE) begin
            if (rx_byte == OP_ARM) begin
               status_q[ST_LATCH_BIT] <= 1'b1;
            end
            if (rx_byte == OP_DISARM || rx_byte == OP_STORE
                || rx_byte == OP_WRITE) begin
               pending_clr_q <= 1'b1;
            end
         end
         if (sel_rise && pending_clr_q) begin
            status_q[ST_LATCH_BIT] <= 1'b0;
            pending_clr_q          <= 1'b0;
         end
         if (sel_fall) begin
            pending_clr_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Serial output
   // ==========================================================
   // Output changes on the falling serial edge; the next byte is loaded
   // on the falling edge after the eighth bit. Loading at the eighth rise
   // would replace the last bit while the master may still sample it.
   logic load_q;

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         shout_q <= 8'h00;
         load_q  <= 1'b0;
      end else if (!active) begin
         load_q  <= 1'b0;
      end else if (byte_done) begin
         load_q  <= 1'b1;
      end else if (sclk_fall && load_q) begin
         load_q  <= 1'b0;
         if (state_q == SNPA_STATUS) begin
            shout_q <= status_q;
         end else if (state_q == SNPA_RDATA) begin
            shout_q <= mem_q[addr_q];
         end
      end else if (sclk_fall) begin
         shout_q <= {shout_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SDO_O    <= 1'b0;
         SDO_OE_O <= 1'b0;
      end else begin
         SDO_OE_O <= active && (state_q == SNPA_RDATA
                     || state_q == SNPA_STATUS);
         SDO_O    <= shout_q[7];
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   sequence sel_rise_s;
      pins_q.sel_n && !sel_old_q;
   endsequence

   // An opcode byte completing; its effect shows one clock later.
   sequence opcode_s(logic [7:0] op);
      byte_done && state_q == SNPA_OPCODE && rx_byte == op;
   endsequence

   latch_power_a: assert property (
      @(posedge CLOCK_I) $rose(RST_N_I) |-> status_q[1] == 1'b0)
      else $error("latch not clear after reset");
   fixed_zero_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (status_q & ~8'h8e) == 8'h00)
      else $error("fixed status bits not zero");
   latch_arm_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (byte_done && state_q == SNPA_OPCODE && rx_byte == OP_ARM)
      |=> status_q[1])
      else $error("arm did not set latch");
   latch_clear_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (pending_clr_q ##0 sel_rise_s) |=> !status_q[1])
      else $error("latch not cleared at select rise");
   pin_block_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (byte_done && state_q == SNPA_SDATA && status_q[7]
       && !pins_q.guard_n) |=> $stable(status_q))
      else $error("status store passed guard pin");
   guard_block_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (byte_done && state_q == SNPA_WDATA
       && guarded(status_q[3:2], addr_q)) |=> halted_q)
      else $error("protected address did not halt burst");
   addr_hold_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (halted_q && state_q == SNPA_WDATA) |=> $stable(addr_q))
      else $error("address moved after halt");
   out_tristate_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      pins_q.sel_n |=> !SDO_OE_O)
      else $error("output driven while deselected");
   frame_end_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      sel_rise_s |=> state_q == SNPA_OPCODE)
      else $error("select rise did not end the command");
   disarm_pend_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      opcode_s(OP_DISARM) |=> pending_clr_q)
      else $error("disarm did not schedule latch clear");
   store_pend_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      opcode_s(OP_STORE) |=> pending_clr_q)
      else $error("store did not schedule latch clear");
   latch_keep_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      store_ok |=> status_q[ST_LATCH_BIT])
      else $error("status store changed the latch");
   store_land_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      store_ok |=> status_q[3:2] == $past(rx_byte[3:2]))
      else $error("guard bits not stored");
   fetch_path_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      opcode_s(OP_FETCH) |=> state_q == SNPA_STATUS)
      else $error("fetch opcode did not select status output");
   addr_load_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (byte_done && state_q == SNPA_ADDR_LO)
      |=> addr_q[7:0] == $past(rx_byte))
      else $error("low address byte not loaded");
   addr_wrap_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (byte_done && state_q == SNPA_RDATA && addr_q == '1)
      |=> addr_q == '0)
      else $error("read address did not wrap");
   commit_byte_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      arr_we |=> mem_q[$past(addr_q)] == $past(rx_byte))
      else $error("data byte not committed");
   read_drive_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (active && state_q == SNPA_RDATA) |=> SDO_OE_O)
      else $error("read data not driven");
   msb_shift_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      (active && sclk_fall && !load_q && state_q == SNPA_RDATA)
      |=> shout_q[7] == $past(shout_q[6]))
      else $error("read data not shifted msb first");
   bad_quiet_a: assert property (
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      state_q == SNPA_IGNORE |=> !SDO_OE_O)
      else $error("output driven after unknown opcode");
endmodule

// ### verilog/snpa_pkg.sv
// Constants, opcodes and carrier types for the serial nonvolatile RAM.
// Assumes a single system clock that oversamples the serial clock.
package snpa_pkg;
   localparam int          SNPA_AW        = 13;
   localparam int          SNPA_DEPTH     = 8192;
   localparam logic [7:0]  OP_ARM         = 8'h06;
   localparam logic [7:0]  OP_DISARM      = 8'h04;
   localparam logic [7:0]  OP_FETCH       = 8'h05;
   localparam logic [7:0]  OP_STORE       = 8'h01;
   localparam logic [7:0]  OP_READ        = 8'h03;
   localparam logic [7:0]  OP_WRITE       = 8'h02;
   localparam int          ST_PIN_EN_BIT  = 7;
   localparam int          ST_GUARD_HI    = 3;
   localparam int          ST_GUARD_LO    = 2;
   localparam int          ST_LATCH_BIT   = 1;
   localparam logic [7:0]  ST_WRITE_MASK  = 8'h8c;
   localparam logic [7:0]  ST_RESET       = 8'h00;
   localparam logic [12:0] GUARD_QUARTER  = 13'h1800;
   localparam logic [12:0] GUARD_HALF     = 13'h1000;
   localparam logic [2:0]  BIT_LAST       = 3'h7;

   typedef enum logic [2:0] {
      SNPA_OPCODE, SNPA_ADDR_HI, SNPA_ADDR_LO, SNPA_WDATA,
      SNPA_RDATA, SNPA_SDATA, SNPA_STATUS, SNPA_IGNORE
   } snpa_state_t;

   typedef struct packed {
      logic sclk;
      logic sel_n;
      logic sdi;
      logic guard_n;
   } snpa_pins_t;
endpackage

// ### tb/snpa_master_model.sv
// Serial bus master model driving the memory slave in mode 0.
// Assumes a free-running system clock; the bench fills tx and calls frame.
`timescale 1ns/1ps
module snpa_master_model
   import snpa_pkg::*;
(
   // System side
   input  wire logic clk_i,
   // Slave output
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i,
   // Pins driven
   output snpa_pins_t pins_o
);
   // =========================================================
   // Frame engine
   logic [7:0] tx[$];
   logic [7:0] rx[$];
   logic       oe_hit;

   initial begin
      pins_o = '{sclk: 1'b0, sel_n: 1'b1, sdi: 1'b0, guard_n: 1'b1};
   end

   // Only this model drives the pins; the bench sets the guard level here.
   task automatic guard(input logic lvl);
      pins_o.guard_n = lvl;
   endtask

   // A serial half period of four system clocks gives 320 ns per bit.
   task automatic half();
      repeat (4) @(posedge clk_i);
      #1;
   endtask

   // The clock stands low between frames; the guard pin is left to the
   // bench so that it is high for a store meant to land.
   task automatic frame();
      logic [7:0] b;
      rx = {};
      oe_hit = 1'b0;
      b = 8'h00;
      pins_o.sel_n = 1'b0;
      half();
      foreach (tx[i]) begin
         for (int k = 7; k >= 0; k--) begin
            pins_o.sdi = tx[i][k];
            half();
            pins_o.sclk = 1'b1;
            half();
            // Sampled late in the bit to leave margin for output latency.
            b[k] = sdo_i;
            oe_hit = oe_hit | sdo_oe_i;
            pins_o.sclk = 1'b0;
         end
         rx.push_back(b);
      end
      half();
      pins_o.sel_n = 1'b1;
      // A released data line must not keep showing its last level.
      pins_o.sdi = ~pins_o.sdi;
      tx = {};
      half();
      half();
   endtask
endmodule

// ### tb/tb_spi_nvram_protect_access.sv
// Self-checking bench for the serial memory slave.
// Assumes the master model sits on the slave pins and drives all frames.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
   n_errors++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
   end end
module tb_spi_nvram_protect_access;
   import snpa_pkg::*;
   // =========================================================
   // Harness
   logic       clk;
   logic       rst_n;
   logic       sdo;
   logic       sdo_oe;
   snpa_pins_t pins;
   int         n_errors;
   int         checked;
   logic [7:0] s;
   logic [7:0] e[4];
   logic [15:0] ad[4] = '{16'h0fff, 16'h1000, 16'h17ff, 16'h1800};

   snpa_top dut (.CLOCK_I(clk), .RST_N_I(rst_n), .SCLK_I(pins.sclk),
      .SEL_N_I(pins.sel_n), .SDI_I(pins.sdi), .GUARD_N_I(pins.guard_n),
      .SDO_O(sdo), .SDO_OE_O(sdo_oe));
   snpa_master_model mdl (.clk_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
      .pins_o(pins));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic op(input logic [7:0] c);
      mdl.tx = '{c};
      mdl.frame();
   endtask
   task automatic fetch(output logic [7:0] v);
      mdl.tx = '{OP_FETCH, 8'h00};
      mdl.frame();
      v = mdl.rx[1];
   endtask
   task automatic store(input logic [7:0] v);
      op(OP_ARM);
      mdl.tx = '{OP_STORE, v};
      mdl.frame();
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      op(OP_ARM);
      mdl.tx = '{OP_WRITE, a[15:8], a[7:0], d};
      mdl.frame();
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      mdl.tx = '{OP_READ, a[15:8], a[7:0], 8'h5a};
      mdl.frame();
      d = mdl.rx[3];
   endtask

   // =========================================================
   // Scenarios
   task automatic t_status();
      fetch(s);
      `CHK("status", 8'h00, s)
      op(OP_ARM);
      fetch(s);
      `CHK("status", 8'h02, s)
      op(OP_DISARM);
      fetch(s);
      `CHK("status", 8'h00, s)
      store(8'hff);
      fetch(s);
      `CHK("status", 8'h8c, s)
   endtask

   task automatic t_pin();
      mdl.guard(1'b0);
      store(8'h00);
      fetch(s);
      `CHK("status", 8'h8c, s)
      mdl.guard(1'b1);
      store(8'h80);
      mdl.guard(1'b0);
      wr(16'h0123, 8'h3c);
      rd(16'h0123, s);
      `CHK("array", 8'h3c, s)
      mdl.tx = '{OP_WRITE, 8'h01, 8'h23, 8'hc3};
      mdl.frame();
      rd(16'h0123, s);
      `CHK("array", 8'h3c, s)
      mdl.guard(1'b1);
      store(8'h00);
   endtask

   task automatic t_wrap();
      op(OP_ARM);
      mdl.tx = '{OP_WRITE, 8'hff, 8'hfe, 8'h11, 8'h22, 8'h33};
      mdl.frame();
      mdl.tx = '{OP_READ, 8'h1f, 8'hfe, 8'ha5, 8'ha5, 8'ha5};
      mdl.frame();
      `CHK("burst", 24'h112233, {mdl.rx[3], mdl.rx[4], mdl.rx[5]})
      `CHK("oe_after", 1'b0, sdo_oe)
   endtask

   task automatic t_blocks();
      logic p;
      for (int g = 0; g < 4; g++) begin
         store(8'(g << 2));
         for (int i = 0; i < 4; i++) begin
            wr(ad[i], 8'(g * 16 + i));
            p = (g == 3) || (g == 2 && ad[i] >= 16'h1000)
                || (g == 1 && ad[i] >= 16'h1800);
            if (!p)
               e[i] = 8'(g * 16 + i);
         end
         for (int i = 0; i < 4; i++) begin
            rd(ad[i], s);
            `CHK("guarded", e[i], s)
         end
      end
      store(8'h04);
      op(OP_ARM);
      mdl.tx = '{OP_WRITE, 8'h17, 8'hfe, 8'h91, 8'h92, 8'h93, 8'h94};
      mdl.frame();
      mdl.tx = '{OP_READ, 8'h17, 8'hff, 8'h00, 8'h00};
      mdl.frame();
      `CHK("halt", {8'h92, e[3]}, {mdl.rx[3], mdl.rx[4]})
   endtask

   task automatic t_bad_op();
      mdl.tx = '{8'h07, 8'h05, 8'h00};
      mdl.frame();
      `CHK("oe_bad", 1'b0, mdl.oe_hit)
   endtask

   initial begin
      n_errors = 0;
      checked = 0;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      t_status();
      t_pin();
      t_wrap();
      t_blocks();
      t_bad_op();
      tally_and_finish();
   end

   // The run needs well under one millisecond; three leaves ample room.
   initial begin
      #3ms;
      n_errors++;
      tally_and_finish();
   end
endmodule
